// file: bench/tb_two_wire_slave_status_engine.sv
// Self-checking bench for the two-wire slave status engine.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/1ps
module tb_two_wire_slave_status_engine;
  import tws_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        scl_in, sda_in, scl_oe, sda_oe, irq, ak, scl_o, sda_o;
  logic [7:0]  paddr, cr, dv, q;
  logic [6:0]  sa;
  logic [31:0] pwdata, prdata;
  int          bad_count, checks, cyc;
  string       nq[$];
  logic [7:0]  eq[$];
  logic [7:0]  codes [3] = '{S_ARB_SW, S_ARB_SR, S_ARB_GC};
  tws_slave_engine DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  tws_bus_master m (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
  // The 20 MHz system clock.
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // ===========================================================
  // Comparison and bus tasks.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    nq.push_back(n);
    eq.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  // Waits for the event interrupt, then reads the status code.
  task automatic ev(input logic [7:0] code);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("irq", 8'h01, {7'h0, irq});
    rd(OFF_STAT, code, "status");
  endtask
  // Next action first, then the flag is cleared in its own write.
  task automatic go(input logic [7:0] c);
    apb(1'b1, OFF_CTRL, c | 8'h08);
    apb(1'b1, OFF_CTRL, c);
  endtask
  // Takes the oldest expected read value whenever a read completes.
  always @(posedge pclk) begin
    if ((psel & penable & ~pwrite & pready) === 1'b1 && nq.size() > 0) begin
      chk(nq.pop_front(), eq.pop_front(), prdata[7:0]);
    end
  end
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 40000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ===========================================================
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bad_count, checks, cyc} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(33));
    sa = 7'($urandom_range(127, 1));
    cr = 8'($urandom) & 8'h83;
    rd(OFF_STAT, S_NONE, "status");
    rd(OFF_CTRL, RST_CTRL, "control");
    rd(8'h14, 8'h00, "unmapped");
    chk("pslverr", 8'h01, {7'h0, pslverr});
    apb(1'b1, OFF_STAT, 8'h55);
    rd(OFF_STAT, S_NONE, "status");
    apb(1'b1, OFF_OWN, {sa, 1'b1});
    apb(1'b1, OFF_AUX, 8'hc0);
    apb(1'b1, OFF_CTRL, cr | 8'h44);
    rd(OFF_CTRL, cr | 8'h44, "control");
    // Receive: addressed, one byte taken, then one refused.
    m.start();
    m.xfer({sa, 1'b0}, 1'b1, q, ak);
    chk("addr_ack", 8'h00, {7'h0, ak});
    ev(S_SW_ACK);
    chk("stretch", 8'h01, {7'h0, scl_oe});
    chk("line_lvl", 8'h00, {6'h0, scl_o, sda_o});
    go(cr | 8'h44);
    dv = 8'($urandom);
    m.xfer(dv, 1'b1, q, ak);
    chk("data_ack", 8'h00, {7'h0, ak});
    ev(S_RX_ACK);
    rd(OFF_DATA, dv, "rx_data");
    go(cr | 8'h40);
    m.xfer(~dv, 1'b1, q, ak);
    chk("data_nak", 8'h01, {7'h0, ak});
    ev(S_RX_NAK);
    go(cr | 8'h40);
    m.stop();
    rd(OFF_STAT, S_NONE, "status");
    // With assert_ack clear the own address is ignored.
    m.start();
    m.xfer({sa, 1'b0}, 1'b1, q, ak);
    chk("isolated", 8'h01, {7'h0, ak});
    m.stop();
    apb(1'b1, OFF_CTRL, cr | 8'h44);
    // General call answered, then refused once disabled.
    m.start();
    m.xfer(8'h00, 1'b1, q, ak);
    chk("gc_ack", 8'h00, {7'h0, ak});
    ev(S_GC_ACK);
    go(cr | 8'h44);
    m.xfer(dv, 1'b1, q, ak);
    ev(S_GRX_ACK);
    rd(OFF_DATA, dv, "gc_data");
    go(cr | 8'h44);
    m.stop();
    ev(S_STOP);
    go(cr | 8'h44);
    apb(1'b1, OFF_OWN, {sa, 1'b0});
    m.start();
    m.xfer(8'h00, 1'b1, q, ak);
    chk("gc_off", 8'h01, {7'h0, ak});
    m.stop();
    apb(1'b1, OFF_OWN, {sa, 1'b1});
    // Transmit a last byte with assert_ack cleared, then all ones.
    m.start();
    m.xfer({sa, 1'b1}, 1'b1, q, ak);
    chk("rd_ack", 8'h00, {7'h0, ak});
    ev(S_SR_ACK);
    dv = 8'($urandom);
    apb(1'b1, OFF_DATA, ~dv);
    go(cr | 8'h44);
    m.xfer(8'hff, 1'b0, q, ak);
    chk("tx_byte", ~dv, q);
    ev(S_TX_ACK);
    apb(1'b1, OFF_DATA, dv);
    go(cr | 8'h40);
    m.xfer(8'hff, 1'b0, q, ak);
    chk("tx_byte", dv, q);
    ev(S_TX_LAST);
    go(cr | 8'h40);
    m.xfer(8'hff, 1'b1, q, ak);
    chk("released", 8'hff, q);
    m.stop();
    rd(OFF_STAT, S_NONE, "status");
    // Addressed while a start is requested, left by recovery.
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_CTRL, cr | 8'h64);
      m.start();
      m.xfer(i == 2 ? 8'h00 : {sa, i[0]}, 1'b1, q, ak);
      ev(codes[i]);
      go(cr | 8'h74);
      repeat (2) @(posedge pclk);
      rd(OFF_CTRL, cr | 8'h64, "control");
      m.stop();
    end
    apb(1'b1, OFF_CTRL, cr | 8'h44);
    // Start inside an address byte, then recovery.
    m.start();
    for (int i = 0; i < 3; i++) m.bit_io(sa[6 - i], ak);
    m.start();
    ev(S_BUSERR);
    go(cr | 8'h54);
    repeat (2) @(posedge pclk);
    rd(OFF_CTRL, cr | 8'h44, "control");
    chk("lines", 8'h00, {6'h0, scl_oe, sda_oe});
    m.stop();
    rd(OFF_STAT, S_NONE, "status");
    final_report();
  end
endmodule

// file: bench/tws_bus_master.sv
// Behavioural two-wire bus master facing the slave pins.
// Assumes pulled-up lines and a 410 ns link clock period.
`timescale 1ns/1ps
module tws_bus_master (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic m_scl;
  logic m_sda;
  // Wired-AND of both parties; a released line floats to the pull-up.
  assign scl_in = m_scl && !scl_oe;
  assign sda_in = m_sda && !sda_oe;
  // The clock stands high outside frames.
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  // One bit: data set while low, clock released, stretching honoured.
  task automatic bit_io(input logic b, output logic r);
    m_sda = b;
    #200;
    m_scl = 1'b1;
    wait (scl_in === 1'b1);
    #200;
    r = sda_in;
    m_scl = 1'b0;
    #10; // Data moves only after the clock fall.
  endtask
  // Start or repeated start from either clock level.
  task automatic start();
    m_sda = 1'b1;
    #200;
    m_scl = 1'b1;
    #200;
    m_sda = 1'b0;
    #200;
    m_scl = 1'b0;
  endtask
  // Stop, leaving both lines high.
  task automatic stop();
    m_sda = 1'b0;
    #200;
    m_scl = 1'b1;
    #200;
    m_sda = 1'b1;
    #200;
  endtask
  // Eight bits MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask
endmodule

// file: bench/tws_slave_engine_props.sv
// Port checks for the two-wire slave status engine.
// Assumes a bind to tws_slave_engine; everything runs on pclk.
`timescale 1ns/1ps
module tws_slave_engine_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        irq
);
  import tws_pkg::*;
  logic [7:0] aux_q;
  logic [7:0] ctl_q;
  // ===========================================================
  // Decodes of completed accesses.
  wire wr_acc  = psel && penable && pwrite && pready;
  wire wr_ctl  = wr_acc && paddr == OFF_CTRL;
  wire rd_stat = psel && penable && !pwrite && pready && paddr == OFF_STAT;
  wire aux_on  = aux_q[B_IRQ_EN] && aux_q[B_GIE];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadows of the aux and control registers, following software writes only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_q <= RST_AUX;
      ctl_q <= RST_CTRL;
    end else if (wr_acc && paddr == OFF_AUX) begin
      aux_q <= pwdata[7:0];
    end else if (wr_ctl) begin
      ctl_q <= pwdata[7:0];
    end
  end
  // ===========================================================
  // Assertions.
  a_status_shape: assert property (
    rd_stat |-> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("status read has stray bits set");
  a_idle_code: assert property (
    rd_stat && aux_on && !irq && !$past(irq) |-> prdata[7:0] == S_NONE)
    else $error("status not idle code while flag is clear");
  a_event_code: assert property (
    rd_stat && aux_on && irq && $past(irq) |-> prdata[7:0] != S_NONE)
    else $error("status shows idle code while flag is set");
  a_irq_gate: assert property (
    irq |-> aux_on || $past(aux_on))
    else $error("interrupt raised without both enables");
  a_stretch_low: assert property (
    $rose(scl_oe) |-> !$past(scl_in))
    else $error("clock stretch began while clock was high");
  a_stretch_release: assert property (
    wr_ctl && !pwdata[B_SI] && scl_oe |-> ##[1:3] !scl_oe)
    else $error("clock still stretched after flag clear");
  a_flag_irq: assert property (
    aux_on && $rose(scl_oe) |-> ##[0:1] irq)
    else $error("stretch without event interrupt");
  a_recover_release: assert property (
    wr_ctl && pwdata[B_STO] && !pwdata[B_SI] |-> ##[1:3] (!scl_oe && !sda_oe))
    else $error("lines not released after recovery");
  a_quiet_off: assert property (
    !ctl_q[B_EN] && !$past(ctl_q[B_EN]) |-> !scl_oe && !sda_oe)
    else $error("disabled unit drives the bus");
endmodule
bind tws_slave_engine tws_slave_engine_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// file: hdl/tws_byte_shift.sv
// Counts frame bits and shifts bytes in and out of the bus.
// Assumes edge pulses from the line monitor, one cycle each.
`timescale 1ns/1ps
module tws_byte_shift (
  input wire logic pclk,
  input wire logic presetn,
  tws_link_if.shf  lk
);
  import tws_pkg::*;

  logic [3:0] cnt;
  logic [7:0] rx;
  logic [7:0] tx;

  // Counts rising clock edges 1 to 9; a START or STOP restarts the frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else if (lk.start_det || lk.stop_det) begin
      cnt <= 4'h0;
    end else if (lk.scl_rise && cnt < ACK_BIT) begin
      cnt <= cnt + 4'h1;
    end else if (lk.scl_fall && cnt == ACK_BIT) begin
      cnt <= 4'h0;
    end
  end

  // Samples data bits on rising edges and shifts send bits on falling edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx <= 8'h00;
      tx <= 8'hff;
    end else begin
      if (lk.scl_rise && cnt < BYTE_BITS) begin
        rx <= {rx[6:0], lk.sda_s};
      end
      if (lk.load) begin
        tx <= lk.load_byte;
      end else if (lk.scl_fall && cnt != 4'h0 && cnt < BYTE_BITS) begin
        tx <= {tx[6:0], 1'b1};
      end
    end
  end

  // Current send bit and the one that follows the next shift.
  assign lk.rx_byte = rx;
  assign lk.bit_cnt = cnt;
  assign lk.tx_bit  = tx[7];
  assign lk.tx_next = tx[6];
endmodule

// file: hdl/tws_line_mon.sv
// Synchronises the bus lines and finds clock edges and START and STOP.
// Assumes scl_in and sda_in are asynchronous pin levels.
`timescale 1ns/1ps
module tws_line_mon (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_in,
  input wire logic sda_in,
  tws_link_if.mon  lk
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;

  // Two synchroniser stages, then one history stage for edge finding.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // Edge and condition pulses are taken from the settled stages only.
  assign lk.scl_s     = scl_q[1];
  assign lk.sda_s     = sda_q[1];
  assign lk.scl_rise  = scl_q[1] & ~scl_q[2];
  assign lk.scl_fall  = ~scl_q[1] & scl_q[2];
  assign lk.start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign lk.stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
endmodule

// file: hdl/tws_slave_engine.sv
// Two-wire slave status engine with an APB register file.
// Assumes open-drain pins resolved outside and an APB master on pclk.
//
// Overview of operation
// - Upper seven bits of the own-address register form the slave address.
// - Address 00H is answered only when general_call_enable is one or the own address is zero.
// - The clock rate bits are stored but steer nothing in slave use.
// - Own address with read bit enters slave transmit, flag and code.
// - Own address with write bit enters slave receive, flag and code.
// - Lost arbitration then read addressing reports B0H as transmitter.
// - Lost arbitration then write addressing reports 68H or 78H.
// - Cleared assert_ack sends a last byte, reports C0H/C8H, then releases.
// - With assert_ack clear no address is answered; bus still watched.
// - Cleared assert_ack makes the next received byte get a not-acknowledge.
// - Status reads F8H whenever the event flag is clear.
// - START or STOP inside a byte or acknowledge reports 00H with flag.
// - Recovery goes not-addressed, clears stop request, releases both lines.
// - Addressing, byte and bus-error events set the flag and wait with a valid code; START or STOP does so only in slave receive.
// - Interrupt needs flag, unit interrupt enable bit 6 and global enable.
// - A set flag stretches SCL low only, except after a bus error; released when flag clears.
// - Status is read-only with its three low bits always zero.
`timescale 1ns/1ps
module tws_slave_engine (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);
  import tws_pkg::*;

  // ==========================================================================
  // Storage
  logic [7:0]  own_addr;
  logic [7:0]  ctrl;
  logic [7:0]  aux;
  logic [7:0]  data_reg;
  logic [7:0]  status_code;
  tws_state_t  state;
  tws_state_t  next_state;
  logic        ack_drv;
  logic        next_ack_drv;
  logic        gc_mode;
  logic        next_gc_mode;
  logic        last_byte;
  logic        mack;
  logic        flag_clr_q;
  logic        ev_set;
  logic [7:0]  ev_code;
  logic        cap_rx;

  tws_link_if lk ();

  tws_line_mon u_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .lk      (lk)
  );

  tws_byte_shift u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk)
  );

  // ==========================================================================
  // APB decode
  wire        setup    = psel & ~penable;
  wire        wr       = psel & penable & pwrite;
  wire        sel_own  = (paddr == OFF_OWN);
  wire        sel_ctrl = (paddr == OFF_CTRL);
  wire        sel_stat = (paddr == OFF_STAT);
  wire        sel_data = (paddr == OFF_DATA);
  wire        sel_aux  = (paddr == OFF_AUX);
  wire        mapped   = sel_own | sel_ctrl | sel_stat | sel_data | sel_aux;
  wire        flag     = ctrl[B_SI];
  wire        en       = ctrl[B_EN];
  wire        aa       = ctrl[B_AA];
  wire        arb      = ctrl[B_STA];
  wire        sto_clr  = flag_clr_q & ctrl[B_STO];
  // Software clearing the flag; a hardware set in the same cycle wins.
  wire        flag_clr = wr & sel_ctrl & flag & ~pwdata[B_SI] & ~ev_set;
  // Outside an event the status shows the idle code only.
  wire [7:0]  stat_view = flag ? status_code : S_NONE;
  wire [7:0]  rd_byte   = sel_own  ? own_addr  :
                          sel_ctrl ? ctrl      :
                          sel_stat ? stat_view :
                          sel_data ? data_reg  :
                          sel_aux  ? aux       : 8'h00;

  // ==========================================================================
  // Bus-side decode
  wire [3:0]  cnt    = lk.bit_cnt;
  wire        cond   = lk.start_det | lk.stop_det;
  wire        fall8  = lk.scl_fall & (cnt == BYTE_BITS);
  wire        fall9  = lk.scl_fall & (cnt == ACK_BIT);
  wire        own_hit = aa & (lk.rx_byte[7:1] == own_addr[7:1]);
  wire        gc_hit  = aa & own_addr[B_GC] & (lk.rx_byte == 8'h00);
  wire        framed  = (state != ST_IDLE) & (state != ST_ERR);
  wire        bad_pos = cond & framed & (cnt > 4'h1);
  wire        shift_now = lk.scl_fall & (cnt != 4'h0) & (cnt < BYTE_BITS);
  wire        tx_drive  = lk.load ? lk.load_byte[7] : shift_now ? lk.tx_next : lk.tx_bit;
  wire        next_sda_oe = (next_ack_drv &
                             (next_state == ST_ADDR_ACK || next_state == ST_RX_ACK)) |
                            ((next_state == ST_TX) & ~tx_drive & ~flag & ~ev_set);

  // The send byte is taken from the data register when the flag is cleared.
  assign lk.load      = flag_clr_q & (state == ST_TX) & ~ctrl[B_STO];
  assign lk.load_byte = data_reg;

  // ==========================================================================
  // Slave sequencer: next state, event and acknowledge decisions.
  always_comb begin
    next_state   = state;
    next_ack_drv = ack_drv;
    next_gc_mode = gc_mode;
    ev_set       = 1'b0;
    ev_code      = S_NONE;
    cap_rx       = 1'b0;
    if (!en) begin
      next_state   = ST_IDLE;
      next_ack_drv = 1'b0;
    end else if (sto_clr) begin
      next_state   = ST_IDLE;
      next_ack_drv = 1'b0;
    end else if (bad_pos) begin
      ev_set       = 1'b1;
      ev_code      = S_BUSERR;
      next_state   = ST_ERR;
      next_ack_drv = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (lk.start_det) begin
            next_state = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (lk.stop_det) begin
            next_state = ST_IDLE;
          end else if (fall8) begin
            if (own_hit || gc_hit) begin
              next_state   = ST_ADDR_ACK;
              next_ack_drv = 1'b1;
              next_gc_mode = gc_hit;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall9) begin
            ev_set       = 1'b1;
            next_ack_drv = 1'b0;
            if (lk.rx_byte[0]) begin
              next_state = ST_TX;
              ev_code    = arb ? S_ARB_SR : S_SR_ACK;
            end else begin
              next_state = ST_RX;
              ev_code    = gc_mode ? (arb ? S_ARB_GC : S_GC_ACK)
                                   : (arb ? S_ARB_SW : S_SW_ACK);
            end
          end
        end
        ST_RX: begin
          if (cond) begin
            ev_set     = 1'b1;
            ev_code    = S_STOP;
            next_state = lk.start_det ? ST_ADDR : ST_IDLE;
          end else if (fall8) begin
            cap_rx       = 1'b1;
            next_ack_drv = aa;
            next_state   = ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (fall9) begin
            ev_set       = 1'b1;
            next_ack_drv = 1'b0;
            next_state   = ack_drv ? ST_RX : ST_IDLE;
            if (gc_mode) begin
              ev_code = ack_drv ? S_GRX_ACK : S_GRX_NAK;
            end else begin
              ev_code = ack_drv ? S_RX_ACK : S_RX_NAK;
            end
          end
        end
        ST_TX: begin
          if (cond) begin
            next_state = lk.start_det ? ST_ADDR : ST_IDLE;
          end else if (fall8) begin
            next_state = ST_TX_ACK;
          end
        end
        ST_TX_ACK: begin
          if (fall9) begin
            ev_set = 1'b1;
            if (!mack) begin
              ev_code    = S_TX_NAK;
              next_state = ST_IDLE;
            end else if (last_byte) begin
              ev_code    = S_TX_LAST;
              next_state = ST_IDLE;
            end else begin
              ev_code    = S_TX_ACK;
              next_state = ST_TX;
            end
          end
        end
        ST_ERR: begin
          next_state = ST_ERR;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer state and the master's acknowledge after a sent byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      ack_drv    <= 1'b0;
      gc_mode    <= 1'b0;
      mack       <= 1'b0;
      last_byte  <= 1'b0;
      flag_clr_q <= 1'b0;
    end else begin
      state      <= next_state;
      ack_drv    <= next_ack_drv;
      gc_mode    <= next_gc_mode;
      flag_clr_q <= flag_clr;
      if (lk.scl_rise && state == ST_TX_ACK && cnt == BYTE_BITS) begin
        mack <= ~lk.sda_s;
      end
      if (lk.load) begin
        last_byte <= ~aa;
      end
    end
  end

  // ==========================================================================
  // Registers: software writes, hardware flag set and stop-request clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr    <= RST_OWN;
      ctrl        <= RST_CTRL;
      aux         <= RST_AUX;
      status_code <= S_NONE;
    end else begin
      if (wr && sel_own) begin
        own_addr <= pwdata[7:0];
      end
      if (wr && sel_aux) begin
        aux <= pwdata[7:0];
      end
      if (wr && sel_ctrl) begin
        // Clock rate bits are kept for read-back only.
        ctrl <= {pwdata[7:4], flag & pwdata[B_SI], pwdata[2:0]};
      end
      if (sto_clr) begin
        ctrl[B_STO] <= 1'b0;
      end
      if (ev_set) begin
        ctrl[B_SI]  <= 1'b1;
        status_code <= ev_code;
      end
    end
  end

  // Data register takes received bytes ahead of software writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= RST_DATA;
    end else if (cap_rx) begin
      data_reg <= lk.rx_byte;
    end else if (wr && sel_data) begin
      data_reg <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Registered outputs: APB answer, line drivers and interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b1;
      pslverr <= 1'b0;
      scl_o   <= 1'b0;
      sda_o   <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      irq     <= 1'b0;
    end else begin
      pready <= 1'b1;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      if (setup) begin
        prdata  <= {24'h00_0000, rd_byte};
        pslverr <= ~mapped;
      end
      // Hold a low clock while the flag is up or a send byte loads, except in the error state; never pull a high one down.
      scl_oe <= en & (flag | ev_set | lk.load) & (state != ST_ERR) &
                (scl_oe | ~lk.scl_s);
      sda_oe <= en & next_sda_oe;
      irq    <= flag & aux[B_IRQ_EN] & aux[B_GIE];
    end
  end
endmodule

// file: inc/tws_link_if.sv
// Carrier between the line monitor, the byte shifter and the slave core.
// Assumes all members run on the one system clock.
`timescale 1ns/1ps
interface tws_link_if;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [7:0] rx_byte;
  logic [3:0] bit_cnt;
  logic       tx_bit;
  logic       tx_next;
  logic       load;
  logic [7:0] load_byte;

  modport mon (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
  modport shf (input scl_rise, scl_fall, start_det, stop_det, sda_s, load, load_byte,
               output rx_byte, bit_cnt, tx_bit, tx_next);
  modport core (input scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det,
                rx_byte, bit_cnt, tx_bit, tx_next, output load, load_byte);
endinterface

// file: inc/tws_pkg.sv
// Shared constants for the two-wire slave status engine.
// Assumes a 32-bit APB slave with byte offsets and an open-drain two-wire bus.
package tws_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_OWN  = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_AUX  = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int B_CR2    = 7;
  localparam int B_EN     = 6;
  localparam int B_STA    = 5;
  localparam int B_STO    = 4;
  localparam int B_SI     = 3;
  localparam int B_AA     = 2;
  localparam int B_CR1    = 1;
  localparam int B_CR0    = 0;
  localparam int B_GC     = 0;
  localparam int B_IRQ_EN = 6;
  localparam int B_GIE    = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_OWN  = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX  = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // ==========================================================================
  // Status codes
  localparam logic [7:0] S_NONE    = 8'hf8;
  localparam logic [7:0] S_BUSERR  = 8'h00;
  localparam logic [7:0] S_SW_ACK  = 8'h60;
  localparam logic [7:0] S_ARB_SW  = 8'h68;
  localparam logic [7:0] S_GC_ACK  = 8'h70;
  localparam logic [7:0] S_ARB_GC  = 8'h78;
  localparam logic [7:0] S_RX_ACK  = 8'h80;
  localparam logic [7:0] S_RX_NAK  = 8'h88;
  localparam logic [7:0] S_GRX_ACK = 8'h90;
  localparam logic [7:0] S_GRX_NAK = 8'h98;
  localparam logic [7:0] S_STOP    = 8'ha0;
  localparam logic [7:0] S_SR_ACK  = 8'ha8;
  localparam logic [7:0] S_ARB_SR  = 8'hb0;
  localparam logic [7:0] S_TX_ACK  = 8'hb8;
  localparam logic [7:0] S_TX_NAK  = 8'hc0;
  localparam logic [7:0] S_TX_LAST = 8'hc8;

  // ==========================================================================
  // Bit counts within a frame
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT   = 4'h9;

  // ==========================================================================
  // Slave engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_ERR
  } tws_state_t;
endpackage
